// file: hdl/aoagc_defs.svh
/*
 * Constants for the output gain-control stage: register offsets, reset values, fixed-point
 * formats. Assumes a 32-bit AHB-Lite register bus and a Q8.16 unsigned gain format.
 */
`ifndef AOAGC_DEFS_SVH
`define AOAGC_DEFS_SVH

`define AOAGC_OFF_CTRL 12'h000
`define AOAGC_OFF_GAIN 12'h004
`define AOAGC_OFF_CEIL 12'h008
`define AOAGC_OFF_TARGET 12'h00C
`define AOAGC_OFF_FAST_THR 12'h010
`define AOAGC_OFF_SLOW_COEF 12'h014
`define AOAGC_OFF_REL 12'h018
`define AOAGC_OFF_FAST_REL 12'h01C
`define AOAGC_OFF_POWER 12'h020
`define AOAGC_OFF_STATUS 12'h024

`define AOAGC_FRAC 16
`define AOAGC_GAIN_RST 24'h010000
`define AOAGC_CEIL_RST 24'hFFFFFF
`define AOAGC_TARGET_RST 24'h000800
`define AOAGC_FAST_THR_RST 24'h000000
`define AOAGC_SLOW_COEF_RST 16'h0148
`define AOAGC_REL_RST 16'hE666
`define AOAGC_FAST_REL_RST 16'h999A
`define AOAGC_PWR_SMOOTH 16'h1000
`define AOAGC_FRAME_RST 16'h0100
`define AOAGC_OFF_FRAME 12'h028

`endif

// file: hdl/aoagc_pkg.sv
/*
 * Types shared by the gain-control stage.
 * Assumes the constants header is included by the files that need offsets.
 */
package aoagc_pkg;
  typedef enum logic [1:0] {
    AOAGC_IDLE,
    AOAGC_HOLD,
    AOAGC_UPDATE
  } aoagc_step_e;
endpackage : aoagc_pkg

// file: hdl/aoagc_fifo.sv
/*
 * Synchronous valid/ready FIFO holding the combined beam words before the gain stage.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module aoagc_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("aoagc_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;
  logic rdy_q, rdy_d;

  // Ready is registered from the next pointers, so it matches the old combinational flag.
  assign in_ready = rdy_q;
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    rdy_d = (wr_d - rd_d) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge hclk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      rdy_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
    end
  end
endmodule : aoagc_fifo
`default_nettype wire

// file: hdl/aoagc_top.sv
/*
 * Output gain-control stage: one adaptive gain applied to four beam outputs.
 * Assumes 16-bit signed samples, one set per sample strobe, the free-running beam on its
 * own port, and an AHB-Lite master that issues single word transfers only.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aoagc_defs.svh"
module aoagc_top #(
  parameter int SW = 16,
  parameter int BEAMS = 4,
  parameter int DEPTH = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [BEAMS*SW-1:0] in_beams,
  input wire logic [SW-1:0] in_free_beam,
  output logic out_valid,
  input wire logic out_ready,
  output logic [BEAMS*SW-1:0] out_beams
);
  initial begin
    if (SW != 16 || BEAMS != 4) $error("aoagc_top serves four 16-bit beams only");
  end

  localparam int W = BEAMS * SW;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus.
  logic ph_q, ph_d, wr_q, wr_d;
  logic [11:0] ad_q, ad_d;
  logic [31:0] rdata_q, rdata_d;
  logic en_q, en_d;
  logic [23:0] gain_q, gain_d, ceil_q, ceil_d, tgt_q, tgt_d, thr_q, thr_d;
  logic [15:0] slow_q, slow_d, rel_q, rel_d, frel_q, frel_d, frame_q, frame_d;
  logic [31:0] pwr_q, pwr_d;
  logic [31:0] inst_q, inst_d;
  logic [15:0] cnt_q, cnt_d;
  logic [1:0] last_dir_q, last_dir_d;
  aoagc_pkg::aoagc_step_e st_q, st_d;

  always_comb begin
    ph_d = hsel && hready && htrans[1];
    wr_d = hwrite;
    ad_d = haddr[11:0];
    rdata_d = 32'h00000000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        `AOAGC_OFF_CTRL: rdata_d = {31'h00000000, en_q};
        `AOAGC_OFF_GAIN: rdata_d = {8'h00, gain_q};
        `AOAGC_OFF_CEIL: rdata_d = {8'h00, ceil_q};
        `AOAGC_OFF_TARGET: rdata_d = {8'h00, tgt_q};
        `AOAGC_OFF_FAST_THR: rdata_d = {8'h00, thr_q};
        `AOAGC_OFF_SLOW_COEF: rdata_d = {16'h0000, slow_q};
        `AOAGC_OFF_REL: rdata_d = {16'h0000, rel_q};
        `AOAGC_OFF_FAST_REL: rdata_d = {16'h0000, frel_q};
        `AOAGC_OFF_POWER: rdata_d = pwr_q;
        `AOAGC_OFF_STATUS: rdata_d = {30'h00000000, last_dir_q};
        `AOAGC_OFF_FRAME: rdata_d = {16'h0000, frame_q};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Sample path: FIFO, then one multiply stage with the shared gain.
  logic f_valid, f_ready;
  logic [W-1:0] f_data;
  logic ov_q, ov_d;
  logic [W-1:0] ob_q, ob_d;
  logic fire;

  aoagc_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_beams),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // The output register empties or stalls the FIFO; a full output holds the sample.
  assign f_ready = !ov_q || out_ready;
  assign fire = f_valid && f_ready;

  function automatic logic [SW-1:0] scale(input logic [SW-1:0] s, input logic [23:0] g);
    logic signed [41:0] p;
    logic signed [41:0] q;
    p = $signed({{26{s[SW-1]}}, s}) * $signed({18'h00000, g});
    q = p >>> `AOAGC_FRAC;
    if (q > 42'sd32767) begin
      scale = 16'h7FFF;
    end else if (q < -42'sd32768) begin
      scale = 16'h8000;
    end else begin
      scale = q[SW-1:0];
    end
  endfunction : scale

  always_comb begin
    ov_d = ov_q;
    ob_d = ob_q;
    if (fire) begin
      ov_d = 1'b1;
      for (int i = 0; i < BEAMS; i++) begin
        ob_d[i*SW +: SW] = scale(f_data[i*SW +: SW], gain_q);
      end
    end else if (out_ready) begin
      ov_d = 1'b0;
    end
  end

  assign out_valid = ov_q;
  assign out_beams = ob_q;

  ////////////////////////////////////////////////////////////////////////////
  // Adaptation: power measured on the free-running beam as it arrives.
  logic [31:0] sq;
  logic [47:0] mix;
  logic [15:0] a;
  logic [23:0] ng;
  logic [47:0] gm;
  logic [31:0] tgt_w;

  always_comb begin
    // Operands are widened first so the square is not cut to the sample width.
    sq = $signed({{16{in_free_beam[SW-1]}}, in_free_beam})
       * $signed({{16{in_free_beam[SW-1]}}, in_free_beam});
    tgt_w = {8'h00, tgt_q};
    en_d = en_q;
    gain_d = gain_q;
    ceil_d = ceil_q;
    tgt_d = tgt_q;
    thr_d = thr_q;
    slow_d = slow_q;
    rel_d = rel_q;
    frel_d = frel_q;
    frame_d = frame_q;
    pwr_d = pwr_q;
    inst_d = inst_q;
    cnt_d = cnt_q;
    st_d = st_q;
    last_dir_d = last_dir_q;
    a = 16'h0000;
    mix = 48'h000000000000;
    gm = 48'h000000000000;
    ng = gain_q;
    if (in_valid && in_ready) begin
      inst_d = sq;
      cnt_d = cnt_q + 16'h0001;
    end
    case (st_q)
      aoagc_pkg::AOAGC_IDLE: begin
        if (cnt_q >= frame_q) begin
          st_d = aoagc_pkg::AOAGC_HOLD;
        end
      end
      aoagc_pkg::AOAGC_HOLD: begin
        // Power smoother: first order, fixed weight.
        mix = 48'(pwr_q) * 48'(16'hFFFF - `AOAGC_PWR_SMOOTH)
            + 48'(inst_q) * 48'(`AOAGC_PWR_SMOOTH);
        pwr_d = mix[47:16];
        st_d = aoagc_pkg::AOAGC_UPDATE;
      end
      aoagc_pkg::AOAGC_UPDATE: begin
        cnt_d = 16'h0000;
        st_d = aoagc_pkg::AOAGC_IDLE;
        if (en_q) begin
          if (pwr_q < tgt_w) begin
            // Raising: the fast coefficient only below the threshold.
            a = (gain_q < thr_q) ? 16'hFFFF - frel_q : slow_q;
            gm = 48'(gain_q) * 48'(17'h10000 + 17'(a));
            ng = (gm[47:40] != 8'h00) ? `AOAGC_CEIL_RST : gm[39:16];
            last_dir_d = 2'b01;
          end else if (pwr_q > tgt_w) begin
            a = (inst_q > pwr_q) ? frel_q : rel_q;
            gm = 48'(gain_q) * 48'(a);
            ng = gm[39:16];
            last_dir_d = 2'b10;
          end else begin
            last_dir_d = 2'b00;
          end
          gain_d = (ng > ceil_q) ? ceil_q : ng;
        end
      end
      default: st_d = aoagc_pkg::AOAGC_IDLE;
    endcase
    if (ph_q && wr_q) begin
      case (ad_q)
        `AOAGC_OFF_CTRL: en_d = hwdata[0];
        `AOAGC_OFF_GAIN: gain_d = hwdata[23:0];
        `AOAGC_OFF_CEIL: ceil_d = hwdata[23:0];
        `AOAGC_OFF_TARGET: tgt_d = hwdata[23:0];
        `AOAGC_OFF_FAST_THR: thr_d = hwdata[23:0];
        `AOAGC_OFF_SLOW_COEF: slow_d = hwdata[15:0];
        `AOAGC_OFF_REL: rel_d = hwdata[15:0];
        `AOAGC_OFF_FAST_REL: frel_d = hwdata[15:0];
        `AOAGC_OFF_FRAME: frame_d = (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 12'h000;
      rdata_q <= 32'h00000000;
      ov_q <= 1'b0;
      ob_q <= '0;
      en_q <= 1'b0;
      gain_q <= `AOAGC_GAIN_RST;
      ceil_q <= `AOAGC_CEIL_RST;
      tgt_q <= `AOAGC_TARGET_RST;
      thr_q <= `AOAGC_FAST_THR_RST;
      slow_q <= `AOAGC_SLOW_COEF_RST;
      rel_q <= `AOAGC_REL_RST;
      frel_q <= `AOAGC_FAST_REL_RST;
      frame_q <= `AOAGC_FRAME_RST;
      pwr_q <= 32'h00000000;
      inst_q <= 32'h00000000;
      cnt_q <= 16'h0000;
      last_dir_q <= 2'b00;
      st_q <= aoagc_pkg::AOAGC_IDLE;
    end else begin
      ph_q <= ph_d;
      wr_q <= wr_d;
      ad_q <= ad_d;
      rdata_q <= rdata_d;
      ov_q <= ov_d;
      ob_q <= ob_d;
      en_q <= en_d;
      gain_q <= gain_d;
      ceil_q <= ceil_d;
      tgt_q <= tgt_d;
      thr_q <= thr_d;
      slow_q <= slow_d;
      rel_q <= rel_d;
      frel_q <= frel_d;
      frame_q <= frame_d;
      pwr_q <= pwr_d;
      inst_q <= inst_d;
      cnt_q <= cnt_d;
      last_dir_q <= last_dir_d;
      st_q <= st_d;
    end
  end
endmodule : aoagc_top
`default_nettype wire

// file: dv/aoagc_monitor.sv
/* Port checker for aoagc_top.
   Assumes the bind at the foot of this file. */
`timescale 1ns/1ps
`default_nettype none
module aoagc_monitor #(
  parameter int SW = 16,
  parameter int BEAMS = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [BEAMS*SW-1:0] out_beams
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire push = in_valid && in_ready;
  wire hole = hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'hF0;
  a_resp_okay: assert property (!hresp) else $error("bad hresp");
  a_no_wait: assert property (hreadyout) else $error("wait state");
  a_out_held: assert property (out_valid && !out_ready |=> out_valid && $stable(out_beams))
    else $error("stalled output moved");
  a_push_out: assert property (push |-> ##[1:2] out_valid) else $error("no output");
  a_full_out: assert property (!in_ready |-> out_valid) else $error("full but idle");
  a_hole_zero: assert property (hole |=> hrdata == 32'h0) else $error("hole read");
  a_out_cause: assert property ($rose(out_valid) |-> $past(push) || $past(push, 2))
    else $error("output without push");
  a_full_cause: assert property ($fell(in_ready) |-> $past(in_valid)) else $error("full unasked");
  c_push: cover property (push);
  c_full: cover property (!in_ready);
  c_stall: cover property (out_valid && !out_ready);
endmodule : aoagc_monitor
////////////////////////////////////////
bind aoagc_top aoagc_monitor #(.SW(SW), .BEAMS(BEAMS)) u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid),
  .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready), .out_beams(out_beams));
`default_nettype wire

// file: dv/aoagc_sink.sv
/* Output mux model taking gained beam words.
   Assumes the gain stage clock; stall holds ready low. */
`timescale 1ns/1ps
`default_nettype none
module aoagc_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stall,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [63:0] out_beams,
  output logic [63:0] last_q,
  output int count_q
);
  // Ready lags stall by one edge, as a registered mux would.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_ready <= 1'b0;
      last_q <= 64'h0;
      count_q <= 0;
    end else begin
      out_ready <= !stall;
      if (out_valid && out_ready) begin
        last_q <= out_beams;
        count_q <= count_q + 1;
      end
    end
  end
endmodule : aoagc_sink
`default_nettype wire

// file: dv/audio_output_agc_tb.sv
/* Bench for the output gain stage: registers, stream, adaptation.
   Assumes the bound checker and the sink model. */
`timescale 1ns/1ps
`default_nettype none
module audio_output_agc_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic in_valid = 1'b0, stall = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d, g, st;
  logic [1:0] htrans = 2'h0;
  logic [63:0] in_beams = 64'h0, out_beams, last;
  logic [15:0] in_free = 16'h0;
  logic hreadyout, hresp, in_ready, out_valid, out_ready;
  int mismatches = 0, cmp_count = 0, cnt, sent = 0;
  always #20 hclk = ~hclk;
  aoagc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .in_valid(in_valid),
    .in_ready(in_ready), .in_beams(in_beams), .in_free_beam(in_free),
    .out_valid(out_valid), .out_ready(out_ready), .out_beams(out_beams));
  aoagc_sink SINK (.hclk(hclk), .hresetn(hresetn), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .out_beams(out_beams), .last_q(last), .count_q(cnt));
  ////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] v);
    cmp_count++;
    if (v !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, v);
    end
  endtask : chk
  // Polls at falling edges, where every update launched by the rising edge has landed.
  task automatic wait_hi(ref logic s);
    @(negedge hclk);
    for (int i = 0; i < 500 && s !== 1'b1; i++) @(negedge hclk);
    if (s !== 1'b1) begin
      chk("handshake", 1'b1, s);
      print_verdict();
    end
  endtask : wait_hi
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_hi(hreadyout);
    @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_hi(hreadyout);
    d = hrdata;
    @(posedge hclk);
  endtask : bus
  task automatic push(input logic [63:0] b);
    in_valid <= 1'b1;
    in_beams <= b;
    in_free <= b[15:0];
    wait_hi(in_ready);
    @(posedge hclk);
    in_valid <= 1'b0;
    sent++;
    for (int i = 0; i < 500 && cnt != sent; i++) @(posedge hclk);
    chk("words out", sent, cnt);
    if (cnt != sent) print_verdict();
  endtask : push
  task automatic adapt(input logic [31:0] ceil, thr, g0, tgt, input logic [15:0] s);
    bus(1'b1, 8'h28, 32'h1);
    bus(1'b1, 8'h08, ceil);
    bus(1'b1, 8'h10, thr);
    bus(1'b1, 8'h0C, tgt);
    bus(1'b1, 8'h04, g0);
    bus(1'b1, 8'h00, 32'h1);
    push({4{s}});
    repeat (4) @(posedge hclk);
    bus(1'b1, 8'h00, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    g = d;
    bus(1'b0, 8'h24, 32'h0);
    st = d;
  endtask : adapt
  ////////////////////////////////////////
  task automatic t_reset();
    bus(1'b0, 8'h04, 32'h0);
    chk("gain", 32'h10000, d);
    bus(1'b0, 8'h18, 32'h0);
    chk("release", 32'hE666, d);
    bus(1'b0, 8'h1C, 32'h0);
    chk("fast release", 32'h999A, d);
    bus(1'b0, 8'h10, 32'h0);
    chk("attack threshold", 32'h0, d);
    bus(1'b1, 8'hF0, 32'hFFFFFFFF);
    bus(1'b0, 8'hF0, 32'h0);
    chk("unmapped", 32'h0, d);
    $display("reset values done");
  endtask : t_reset
  task automatic t_frozen();
    bus(1'b1, 8'h04, 32'h20000);
    push(64'h7000_FF00_0200_0100);
    chk("beams", 64'h7FFF_FE00_0400_0200, last);
    bus(1'b0, 8'h04, 32'h0);
    chk("frozen gain", 32'h20000, d);
    $display("frozen gain done");
  endtask : t_frozen
  task automatic t_adapt();
    adapt(32'hFFFFFF, 32'h0, 32'h10000, 32'h0, 16'h4000);
    chk("fast release", 1'b1, g < 32'hA000);
    chk("one step", 1'b1, g > 32'h9000);
    chk("down", 32'h2, st);
    adapt(32'h10000, 32'h0, 32'h10000, 32'hFFFFFF, 16'h0010);
    chk("ceiling", 32'h10000, g);
    chk("up", 32'h1, st);
    adapt(32'hFFFFFF, 32'h20000, 32'h8000, 32'hFFFFFF, 16'h0010);
    chk("fast attack", 1'b1, g > 32'hA000);
    $display("adaptation done");
  endtask : t_adapt
  task automatic t_fill();
    int n;
    stall <= 1'b1;
    repeat (2) @(posedge hclk);
    in_valid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge hclk);
      if (in_ready !== 1'b1) break;
      @(posedge hclk);
    end
    @(posedge hclk);
    in_valid <= 1'b0;
    chk("capacity", 1'b1, n >= 32 && n <= 34);
    repeat (8) @(posedge hclk);
    chk("full refuses", 1'b0, in_ready);
    stall <= 1'b0;
    sent += n;
    for (int i = 0; i < 500 && cnt != sent; i++) @(posedge hclk);
    chk("drained", sent, cnt);
    if (cnt != sent) print_verdict();
    $display("fill and drain done");
  endtask : t_fill
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_frozen();
    t_adapt();
    t_fill();
    print_verdict();
  end
endmodule : audio_output_agc_tb
`default_nettype wire
